// ### bench/nsc_host_model.sv
// Host model driving the register port, datapath enable and fast chip select
`timescale 1ns/10ps
module nsc_host_model (
	input  wire logic        clk_sys,
	input  wire logic [7:0]  reg_rdata,
	output logic      [11:0] reg_addr,
	output logic      [7:0]  reg_wdata,
	output logic             reg_write,
	output logic             reg_read,
	output logic             datapath_enable,
	output logic             fast_chip_select
);
	// Idle levels at time zero, fast port idle high
	initial begin
		reg_addr = 12'h000;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
		datapath_enable = 1'b0;
		fast_chip_select = 1'b1;
	end

	// One register write; released lines show the inverse of the last value
	task wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		if (a == 12'h300 || a == 12'h301) datapath_enable = 1'b0;
		if (a == 12'h302) fast_chip_select = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		@(negedge clk_sys);
		reg_write = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : wr

	// One register read, data taken one cycle after the strobe
	task rd(input logic [11:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_read = 1'b1;
		@(negedge clk_sys);
		reg_read = 1'b0;
		d = reg_rdata;
		reg_addr = ~a;
	endtask : rd

	// Datapath enable level change
	task set_dp(input logic v);
		@(negedge clk_sys);
		datapath_enable = v;
	endtask : set_dp

	// One fast port frame: chip select low for a cycle, then rising edge
	task cs_pulse;
		@(negedge clk_sys);
		fast_chip_select = 1'b0;
		@(negedge clk_sys);
		fast_chip_select = 1'b1;
	endtask : cs_pulse
endmodule : nsc_host_model

// ### bench/tb_top.sv
// Self-checking bench for the oscillator sync control block
`timescale 1ns/10ps
module tb_top;
	logic        clk_sys, rst_n, reg_write, reg_read, datapath_enable, sysref, upconverter_channel_zero_i_lsb;
	logic        fast_chip_select, fast_sync_flag, fast_dither_enable, dither_enable;
	logic        fast_reconfig_enable, self_coherent_select, synthesis_active, mixer_enable;
	logic        sync_event, dither_active, upconverter_channel_zero_lsb_out;
	logic [11:0] reg_addr;
	logic [7:0]  reg_wdata, reg_rdata;
	logic [3:0]  fast_accumulator_reset_select, ref_from_channel_zero, phase_continuous_select;
	logic [3:0]  accumulator_reset, phase_seed;
	int          fails, cmp_count;

	nsc_sync_source_config_control u_nsc_sync_source_config_control (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_write,
		.reg_read, .reg_rdata, .datapath_enable, .sysref, .upconverter_channel_zero_i_lsb, .fast_chip_select, .fast_sync_flag,
		.fast_accumulator_reset_select, .fast_dither_enable, .dither_enable, .fast_reconfig_enable,
		.self_coherent_select, .ref_from_channel_zero, .synthesis_active, .mixer_enable,
		.phase_continuous_select, .sync_event, .accumulator_reset, .phase_seed, .dither_active, .upconverter_channel_zero_lsb_out);
	nsc_host_model u_host (.clk_sys, .reg_rdata, .reg_addr, .reg_wdata, .reg_write, .reg_read,
		.datapath_enable, .fast_chip_select);

	// 50 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Compare and report
	task check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// Verdict and end of run
	task results;
		$display("Comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : results

	// Count event pulses over a fixed window, checking masks on each
	task expect_event(input int n, input int cyc, input logic [3:0] acc, input logic [3:0] seed);
		int seen;
		seen = 0;
		for (int i = 0; i < cyc; i++) begin
			if (sync_event === 1'b1) begin
				seen++;
				check(8'(accumulator_reset), 8'(acc));
				check(8'(phase_seed), 8'(seed));
			end
			@(negedge clk_sys);
		end
		check(8'(seen), 8'(n));
	endtask : expect_event

	// One SYSREF pulse
	task pulse_sysref;
		@(negedge clk_sys);
		sysref = 1'b1;
		@(negedge clk_sys);
		sysref = 1'b0;
	endtask : pulse_sysref

	// Sixteen LSb samples; event expected only after the last one
	task lsb_seq(input logic [15:0] pat, input logic force0);
		for (int i = 0; i <= 16; i++) begin
			@(negedge clk_sys);
			if (i > 0) begin
				check(8'(sync_event), 8'(i == 16));
				if (i < 16) check(8'(upconverter_channel_zero_lsb_out), force0 ? 8'h00 : 8'(pat[16 - i]));
			end
			if (i < 16) upconverter_channel_zero_i_lsb = pat[15 - i];
		end
		upconverter_channel_zero_i_lsb = 1'b0;
	endtask : lsb_seq

	////////////////////////////////////////////////////////////////////////////////
	// Reset values, full-width access, unmapped address
	task t_regs;
		logic [7:0] d;
		for (int i = 0; i < 5; i++) begin
			u_host.rd(12'h300 + 12'(i), d);
			check(d, (i == 3) ? 8'h0f : 8'h00);
		end
		u_host.wr(12'h303, 8'hf5);
		u_host.rd(12'h303, d);
		check(d, 8'hf5);
		u_host.wr(12'h305, 8'ha5);
		u_host.rd(12'h305, d);
		check(d, 8'h00);
	endtask : t_regs

	// Control bits and phase-continuous selection
	task t_control;
		logic [7:0] d;
		u_host.wr(12'h300, 8'h07);
		u_host.wr(12'h301, 8'h05);
		u_host.rd(12'h301, d);
		check(d, 8'h05);
		check(8'(mixer_enable), 8'h01);
		check(8'(self_coherent_select), 8'h01);
		check(8'(ref_from_channel_zero), 8'h0a);
		check(8'(phase_continuous_select), 8'h05);
		check(8'(synthesis_active), 8'h00);
		u_host.set_dp(1'b1);
		repeat (2) @(negedge clk_sys);
		check(8'(synthesis_active), 8'h01);
		u_host.set_dp(1'b0);
	endtask : t_control

	// Serial sources: immediate, one-shot SYSREF, every SYSREF, LSb pattern
	task t_serial;
		dither_enable = 1'b1;
		u_host.wr(12'h302, 8'h00);
		u_host.wr(12'h304, 8'h01);
		expect_event(1, 4, 4'h5, 4'ha);
		check(8'(dither_active), 8'h01);
		u_host.wr(12'h304, 8'h01);
		expect_event(0, 4, 4'h5, 4'ha);
		u_host.wr(12'h304, 8'h00);
		u_host.wr(12'h302, 8'h01);
		u_host.wr(12'h304, 8'h01);
		expect_event(0, 3, 4'h5, 4'ha);
		for (int k = 0; k < 2; k++) begin
			pulse_sysref;
			expect_event(k == 0, 3, 4'h5, 4'ha);
		end
		u_host.wr(12'h304, 8'h00);
		u_host.wr(12'h302, 8'h02);
		u_host.wr(12'h304, 8'h01);
		for (int k = 0; k < 3; k++) begin
			if (k == 2) u_host.wr(12'h304, 8'h00);
			pulse_sysref;
			expect_event(k < 2, 3, 4'h5, 4'ha);
		end
		u_host.wr(12'h302, 8'h03);
		u_host.wr(12'h304, 8'h01);
		lsb_seq(16'h0e0f, 1'b0);
		u_host.wr(12'h304, 8'h00);
		u_host.wr(12'h302, 8'h00);
	endtask : t_serial

	// Fast sources: chip select edge, ignored software sync, reserved one-shot SYSREF code, pattern wait
	task t_fast;
		fast_accumulator_reset_select = 4'h9;
		fast_dither_enable = 1'b0;
		fast_sync_flag = 1'b1;
		u_host.wr(12'h300, 8'h87);
		check(8'(fast_reconfig_enable), 8'h01);
		u_host.cs_pulse;
		expect_event(1, 3, 4'h9, 4'ha);
		check(8'(dither_active), 8'h00);
		u_host.wr(12'h304, 8'h01);
		expect_event(0, 4, 4'h9, 4'ha);
		u_host.wr(12'h304, 8'h00);
		fast_sync_flag = 1'b0;
		u_host.cs_pulse;
		expect_event(0, 3, 4'h9, 4'ha);
		fast_sync_flag = 1'b1;
		u_host.wr(12'h302, 8'h01);
		u_host.cs_pulse;
		expect_event(0, 3, 4'h9, 4'ha);
		pulse_sysref;
		expect_event(0, 3, 4'h9, 4'ha);
		u_host.wr(12'h302, 8'h03);
		u_host.cs_pulse;
		lsb_seq(16'h000f, 1'b1);
		@(negedge clk_sys);
		upconverter_channel_zero_i_lsb = 1'b1;
		@(negedge clk_sys);
		check(8'(upconverter_channel_zero_lsb_out), 8'h01);
		upconverter_channel_zero_i_lsb = 1'b0;
	endtask : t_fast

	// Mid-run reset restores the register defaults
	task t_reset;
		logic [7:0] d;
		rst_n = 1'b0;
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		check(8'(fast_reconfig_enable), 8'h00);
		u_host.rd(12'h303, d);
		check(d, 8'h0f);
	endtask : t_reset

	////////////////////////////////////////////////////////////////////////////////
	// Reset, scenarios, verdict
	initial begin
		rst_n = 1'b0;
		sysref = 1'b0;
		upconverter_channel_zero_i_lsb = 1'b0;
		fast_sync_flag = 1'b0;
		fast_accumulator_reset_select = 4'h0;
		fast_dither_enable = 1'b0;
		dither_enable = 1'b0;
		fails = 0;
		cmp_count = 0;
		repeat (20) @(negedge clk_sys);
		rst_n = 1'b1;
		t_regs;
		t_control;
		t_serial;
		t_fast;
		t_reset;
		results;
	end
endmodule : tb_top

// ### src/nsc_pkg.sv
// Constants shared by the oscillator sync control block
package nsc_pkg;
	// Register offsets
	localparam logic [11:0] ADDR_OSC_CTRL   = 12'h300;
	localparam logic [11:0] ADDR_PHASE_CONT = 12'h301;
	localparam logic [11:0] ADDR_SYNC_SRC   = 12'h302;
	localparam logic [11:0] ADDR_ACC_RESET  = 12'h303;
	localparam logic [11:0] ADDR_SW_SYNC    = 12'h304;

	// Reset values
	localparam logic [7:0] RST_OSC_CTRL   = 8'h00;
	localparam logic [7:0] RST_PHASE_CONT = 8'h00;
	localparam logic [7:0] RST_SYNC_SRC   = 8'h00;
	localparam logic [7:0] RST_ACC_RESET  = 8'h0f;
	localparam logic [7:0] RST_SW_SYNC    = 8'h00;

	// Field positions in oscillator_control and the software sync register
	localparam int BIT_FAST_RECONFIG = 7;
	localparam int BIT_SELF_COHERENT = 2;
	localparam int BIT_SYNTHESIS     = 1;
	localparam int BIT_MIXER         = 0;
	localparam int BIT_SW_SYNC       = 0;

	// Sync source encodings
	localparam logic [1:0] SRC_IMMEDIATE  = 2'h0;
	localparam logic [1:0] SRC_SYSREF_ONE = 2'h1;
	localparam logic [1:0] SRC_SYSREF_ALL = 2'h2;
	localparam logic [1:0] SRC_LSB_PATTERN = 2'h3;

	// Pattern lengths in samples
	localparam logic [2:0] PAT_LOW_SAMPLES  = 3'h4;
	localparam logic [2:0] PAT_HIGH_SAMPLES = 3'h4;

	// Block state, apart from the registered mode flags
	typedef struct packed {
		logic [7:0] osc_ctrl;
		logic [7:0] phase_cont;
		logic [7:0] sync_src;
		logic [7:0] acc_sel;
		logic [7:0] sw_sync;
		logic [7:0] rdata;
		logic       armed;
		logic       waiting;
		logic [2:0] low_cnt;
		logic [2:0] high_cnt;
		logic       sysref_prev;
		logic       cs_prev;
		logic       sync_event;
		logic [3:0] acc_reset;
		logic [3:0] phase_seed;
		logic       dither_active;
		logic       lsb_out;
	} nsc_state_t;
endpackage : nsc_pkg

// ### src/nsc_sync_source_config_control.sv
// Oscillator control registers and sync event logic
`timescale 1ns/10ps
module nsc_sync_source_config_control (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic [11:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [7:0]  reg_rdata,
	input  wire logic        datapath_enable,
	input  wire logic        sysref,
	input  wire logic        upconverter_channel_zero_i_lsb,
	input  wire logic        fast_chip_select,
	input  wire logic        fast_sync_flag,
	input  wire logic [3:0]  fast_accumulator_reset_select,
	input  wire logic        fast_dither_enable,
	input  wire logic        dither_enable,
	output logic             fast_reconfig_enable,
	output logic             self_coherent_select,
	output logic [3:0]       ref_from_channel_zero,
	output logic             synthesis_active,
	output logic             mixer_enable,
	output logic [3:0]       phase_continuous_select,
	output logic             sync_event,
	output logic [3:0]       accumulator_reset,
	output logic [3:0]       phase_seed,
	output logic             dither_active,
	output logic             upconverter_channel_zero_lsb_out
);

	////////////////////////////////////////////////////////////////////////////
	// State registers
	nsc_pkg::nsc_state_t state_reg;
	nsc_pkg::nsc_state_t state_next;
	logic                synth_reg;
	logic [3:0]          refsel_reg;

	// Address match used by both write and read decode
	function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] offset);
		addr_hit = (addr == offset);
	endfunction : addr_hit

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	logic       fast_mode;
	logic [1:0] source;
	logic       sw_level;
	logic       sw_rise;
	logic       sysref_rise;
	logic       cs_rise;
	logic       hunting;
	logic       pattern_hit;
	logic       trigger;

	// Register writes, reads, trigger selection and pattern hunt
	always_comb begin
		state_next            = state_reg;
		fast_mode             = state_reg.osc_ctrl[nsc_pkg::BIT_FAST_RECONFIG];
		source                = state_reg.sync_src[1:0];
		sw_level              = state_reg.sw_sync[nsc_pkg::BIT_SW_SYNC];
		sysref_rise           = sysref & ~state_reg.sysref_prev;
		cs_rise               = fast_chip_select & ~state_reg.cs_prev;
		sw_rise               = reg_write && addr_hit(reg_addr, nsc_pkg::ADDR_SW_SYNC)
		                        && reg_wdata[nsc_pkg::BIT_SW_SYNC] && !sw_level;
		pattern_hit           = 1'b0;
		trigger               = 1'b0;
		state_next.sysref_prev = sysref;
		state_next.cs_prev    = fast_chip_select;

		// Register writes
		if (reg_write) begin
			if (addr_hit(reg_addr, nsc_pkg::ADDR_OSC_CTRL)) begin
				state_next.osc_ctrl = reg_wdata;
			end
			if (addr_hit(reg_addr, nsc_pkg::ADDR_PHASE_CONT)) begin
				state_next.phase_cont = reg_wdata;
			end
			if (addr_hit(reg_addr, nsc_pkg::ADDR_SYNC_SRC)) begin
				state_next.sync_src = reg_wdata;
			end
			if (addr_hit(reg_addr, nsc_pkg::ADDR_ACC_RESET)) begin
				state_next.acc_sel = reg_wdata;
			end
			if (addr_hit(reg_addr, nsc_pkg::ADDR_SW_SYNC)) begin
				state_next.sw_sync = reg_wdata;
			end
		end

		// Register reads, unmapped addresses answer zero
		if (reg_read) begin
			if (addr_hit(reg_addr, nsc_pkg::ADDR_OSC_CTRL)) begin
				state_next.rdata = state_reg.osc_ctrl;
			end else if (addr_hit(reg_addr, nsc_pkg::ADDR_PHASE_CONT)) begin
				state_next.rdata = state_reg.phase_cont;
			end else if (addr_hit(reg_addr, nsc_pkg::ADDR_SYNC_SRC)) begin
				state_next.rdata = state_reg.sync_src;
			end else if (addr_hit(reg_addr, nsc_pkg::ADDR_ACC_RESET)) begin
				state_next.rdata = state_reg.acc_sel;
			end else if (addr_hit(reg_addr, nsc_pkg::ADDR_SW_SYNC)) begin
				state_next.rdata = state_reg.sw_sync;
			end else begin
				state_next.rdata = 8'h00;
			end
		end

		// Pattern hunt runs only while a pattern trigger is bound
		hunting = fast_mode ? state_reg.waiting
		                    : (sw_level && source == nsc_pkg::SRC_LSB_PATTERN);
		if (!hunting) begin
			state_next.low_cnt  = 3'h0;
			state_next.high_cnt = 3'h0;
		end else if (!upconverter_channel_zero_i_lsb) begin
			// Low run saturates at its minimum length
			state_next.high_cnt = 3'h0;
			if (state_reg.low_cnt != nsc_pkg::PAT_LOW_SAMPLES) begin
				state_next.low_cnt = state_reg.low_cnt + 3'h1;
			end
		end else if (state_reg.low_cnt == nsc_pkg::PAT_LOW_SAMPLES) begin
			if (state_reg.high_cnt == nsc_pkg::PAT_HIGH_SAMPLES - 3'h1) begin
				pattern_hit         = 1'b1;
				state_next.low_cnt  = 3'h0;
				state_next.high_cnt = 3'h0;
			end else begin
				state_next.high_cnt = state_reg.high_cnt + 3'h1;
			end
		end else begin
			state_next.low_cnt  = 3'h0;
			state_next.high_cnt = 3'h0;
		end

		// Trigger selection
		if (fast_mode) begin
			unique case (source)
				nsc_pkg::SRC_IMMEDIATE: trigger = cs_rise && fast_sync_flag;
				nsc_pkg::SRC_LSB_PATTERN: trigger = pattern_hit;
				default: trigger = 1'b0;
			endcase
		end else begin
			unique case (source)
				nsc_pkg::SRC_IMMEDIATE: trigger = sw_rise;
				nsc_pkg::SRC_SYSREF_ONE: trigger = sysref_rise && state_reg.armed;
				nsc_pkg::SRC_SYSREF_ALL: trigger = sysref_rise && sw_level;
				nsc_pkg::SRC_LSB_PATTERN: trigger = pattern_hit;
			endcase
		end

		// One-shot arm: a new arming in the firing cycle wins
		if (!fast_mode && source == nsc_pkg::SRC_SYSREF_ONE && sw_rise) begin
			state_next.armed = 1'b1;
		end else if (trigger || fast_mode || source != nsc_pkg::SRC_SYSREF_ONE) begin
			state_next.armed = 1'b0;
		end

		// Fast-mode wait for the pattern after chip select rises
		if (fast_mode && source == nsc_pkg::SRC_LSB_PATTERN && cs_rise && fast_sync_flag) begin
			state_next.waiting = 1'b1;
		end else if (pattern_hit || !fast_mode || source != nsc_pkg::SRC_LSB_PATTERN) begin
			state_next.waiting = 1'b0;
		end

		// Event outputs: reset mask and dither from the bank that fast mode selects, seed always from phase_cont
		state_next.sync_event = trigger;
		state_next.acc_reset  = 4'h0;
		state_next.phase_seed = 4'h0;
		if (trigger) begin
			state_next.acc_reset     = fast_mode ? fast_accumulator_reset_select
			                                     : state_reg.acc_sel[3:0];
			state_next.phase_seed    = ~state_reg.phase_cont[3:0];
			state_next.dither_active = fast_mode ? fast_dither_enable : dither_enable;
		end

		// LSb reads as zero while the fast pattern wait is open
		state_next.lsb_out = (fast_mode && state_reg.waiting) ? 1'b0 : upconverter_channel_zero_i_lsb;
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg            <= '0;
			state_reg.osc_ctrl   <= nsc_pkg::RST_OSC_CTRL;
			state_reg.phase_cont <= nsc_pkg::RST_PHASE_CONT;
			state_reg.sync_src   <= nsc_pkg::RST_SYNC_SRC;
			state_reg.acc_sel    <= nsc_pkg::RST_ACC_RESET;
			state_reg.sw_sync    <= nsc_pkg::RST_SW_SYNC;
			state_reg.cs_prev    <= 1'b1; // Chip select idles high, so no false edge after reset
		end else begin
			state_reg <= state_next;
		end
	end

	// Derived mode flags registered so every output leaves a flip-flop
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			synth_reg  <= 1'b0;
			refsel_reg <= 4'h0;
		end else begin
			synth_reg  <= state_next.osc_ctrl[nsc_pkg::BIT_SYNTHESIS] & datapath_enable;
			refsel_reg <= {4{state_next.osc_ctrl[nsc_pkg::BIT_SELF_COHERENT]}}
			              & ~state_next.phase_cont[3:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign reg_rdata               = state_reg.rdata;
	assign fast_reconfig_enable    = state_reg.osc_ctrl[nsc_pkg::BIT_FAST_RECONFIG];
	assign self_coherent_select    = state_reg.osc_ctrl[nsc_pkg::BIT_SELF_COHERENT];
	assign ref_from_channel_zero   = refsel_reg;
	assign synthesis_active        = synth_reg;
	assign mixer_enable            = state_reg.osc_ctrl[nsc_pkg::BIT_MIXER];
	assign phase_continuous_select = state_reg.phase_cont[3:0];
	assign sync_event              = state_reg.sync_event;
	assign accumulator_reset       = state_reg.acc_reset;
	assign phase_seed              = state_reg.phase_seed;
	assign dither_active           = state_reg.dither_active;
	assign upconverter_channel_zero_lsb_out            = state_reg.lsb_out;

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	a_immediate_sync: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(sw_rise && !fast_mode && source == nsc_pkg::SRC_IMMEDIATE) |=> sync_event)
		else $error("software sync did not fire at once");

	a_reset_bank: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(trigger && !fast_mode) |=> (accumulator_reset == $past(state_reg.acc_sel[3:0])))
		else $error("accumulator reset mask wrong");

	a_fast_bank: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(trigger && fast_mode) |=> (accumulator_reset == $past(fast_accumulator_reset_select)))
		else $error("fast reset mask wrong");

	a_seed_mask: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sync_event |-> (phase_seed == ~phase_continuous_select))
		else $error("phase seed mask wrong");

	a_no_event_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!sync_event |-> (accumulator_reset == 4'h0 && phase_seed == 4'h0))
		else $error("event outputs active without event");

	a_arm_once: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(trigger && !fast_mode && source == nsc_pkg::SRC_SYSREF_ONE && !sw_rise) |=> !state_reg.armed)
		else $error("one-shot arm not cleared");

	a_sysref_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!fast_mode && source == nsc_pkg::SRC_SYSREF_ALL && sw_level && sysref && !$past(sysref))
		|=> sync_event)
		else $error("sysref edge missed");

	a_pattern_fire: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(hunting && !upconverter_channel_zero_i_lsb) [*4] ##1 (hunting && upconverter_channel_zero_i_lsb) [*4] |=> sync_event)
		else $error("lsb pattern did not fire");

	a_lsb_masked: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(fast_mode && state_reg.waiting) |=> !upconverter_channel_zero_lsb_out)
		else $error("lsb not forced low while waiting");

	a_fast_edge: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(fast_mode && source == nsc_pkg::SRC_IMMEDIATE && fast_sync_flag
		 && fast_chip_select && !state_reg.cs_prev) |=> sync_event)
		else $error("chip select edge missed");

	a_synth_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
		synthesis_active |-> $past(datapath_enable))
		else $error("synthesis active without datapath");

	a_fast_refused: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(fast_mode && (source == nsc_pkg::SRC_SYSREF_ONE || source == nsc_pkg::SRC_SYSREF_ALL)) |=> !sync_event)
		else $error("event from a reserved fast source");

	a_sw_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(fast_mode && source == nsc_pkg::SRC_IMMEDIATE && !(cs_rise && fast_sync_flag)) |=> !sync_event)
		else $error("software sync acted in fast mode");

	a_fast_dither: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(trigger && fast_mode) |=> (dither_active == $past(fast_dither_enable)))
		else $error("fast dither not applied");

	a_refsel_coherent: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ref_from_channel_zero == ({4{self_coherent_select}} & ~phase_continuous_select))
		else $error("reference select does not follow control");

endmodule : nsc_sync_source_config_control
